// ==== core/diag_selftest.v ====
// test pattern generator and self-test status with wishbone registers
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/10ps
`include "diag_defines.vh"

module diag_selftest (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    // pixel stream
    input  wire [7:0]  sensor_pix_i,
    input  wire        sensor_valid_i,
    input  wire        ext_trigger_i,
    output reg  [7:0]  pix_o,
    output reg         pix_valid_o,
    output reg         line_start_o,
    // self-test check inputs
    input  wire [31:0] check_faults_i,
    input  wire        overheat_i,
    input  wire        save_setup_ok_i,
    input  wire        save_offset_ok_i,
    input  wire        save_gain_ok_i,
    // indicator and interrupt
    input  wire [1:0]  indicator_state_i,
    output wire [1:0]  indicator_o,
    output wire        irq_o
);

    // states of the line sequencer
    localparam ST_IDLE = 2'b01;
    localparam ST_LINE = 2'b10;

    reg  [31:0] ctrl_r;
    reg  [31:0] fault_r;
    reg  [15:0] period_r;
    reg  [2:0]  irq_stat_r;
    reg  [2:0]  irq_mask_r;
    reg  [1:0]  state_r;
    reg  [15:0] col_r;
    reg  [15:0] rate_cnt_r;
    reg  [15:0] line_cnt_r;
    reg  [7:0]  vval_r;
    reg  [2:0]  trg_sync_r;
    reg         trg_prev_r;
    reg  [31:0] fault_nxt;
    reg  [7:0]  out_pix_nxt;
    reg         out_valid_nxt;
    reg  [7:0]  pat_nxt;
    reg  [31:0] rd_nxt;
    wire [1:0]  pat_sel;
    wire        trig_int;
    wire        wr_stb;
    wire        refresh;
    wire        trg_edge;
    wire        line_go;
    wire        fault_rise;
    wire [7:0]  hval;
    wire [7:0]  sval;
    wire [6:0]  step_blk;
    wire        line_end;
    wire        rd_req;
    wire        wr_ctrl;
    wire        wr_period;
    wire        wr_irq_stat;
    wire        wr_irq_mask;
    wire [2:0]  irq_clr;
    wire [2:0]  irq_set;
    wire [31:0] period_wr;

    function [31:0] mask_write;
        input [31:0] old;
        input [31:0] wd;
        input [3:0]  be;
        integer k;
        begin
            mask_write = old;
            for (k = 0; k < 4; k = k + 1) begin
                if (be[k])
                    mask_write[k*8 +: 8] = wd[k*8 +: 8];
            end
        end
    endfunction

    // stepped value of a 512-pixel block, held at the last step
    function [7:0] step_value;
        input [6:0] blk;
        begin
            if (blk > `STEP_LAST_BLK)
                step_value = `STEP_LAST;
            else
                step_value = `STEP_START + {blk[5:0], 2'b00};
        end
    endfunction

    // vertical ramp value for the line after the one just finished
    function [7:0] vramp_next;
        input [15:0] lines_done;
        input [7:0]  cur;
        begin
            if (lines_done == 16'h0000)
                vramp_next = `VRAMP_SECOND;
            else
                vramp_next = cur + `VRAMP_INC;
        end
    endfunction

    assign pat_sel  = ctrl_r[`CTRL_PAT_HI:`CTRL_PAT_LO];
    assign trig_int = ctrl_r[`CTRL_TRIG_INT];
    // a request is taken on the edge that raises ack
    assign rd_req      = cyc_i & stb_i & ~we_i & ~ack_o;
    assign wr_stb      = cyc_i & stb_i & we_i & ~ack_o;
    assign wr_ctrl     = wr_stb & (adr_i == `REG_CTRL);
    assign wr_period   = wr_stb & (adr_i == `REG_LINE_PERIOD);
    assign wr_irq_stat = wr_stb & (adr_i == `REG_IRQ_STATUS) & sel_i[0];
    assign wr_irq_mask = wr_stb & (adr_i == `REG_IRQ_MASK) & sel_i[0];
    assign refresh     = wr_ctrl & sel_i[0] & dat_i[`CTRL_REFRESH];
    assign period_wr   = mask_write({16'h0, period_r}, dat_i, sel_i);
    assign irq_clr     = wr_irq_stat ? dat_i[2:0] : 3'h0;
    assign irq_set     = {refresh, line_go, fault_rise};
    assign indicator_o = indicator_state_i;
    assign irq_o       = |(irq_stat_r & irq_mask_r);

    // external trigger: three-stage sync, edge once stages 2 and 3 agree
    assign trg_edge = trg_sync_r[1] & trg_sync_r[2] & ~trg_prev_r;
    assign line_go  = trig_int ? (rate_cnt_r == 16'h0000)
                               : trg_edge;

    // pattern values per column; slices wrap naturally at 8 bits
    assign hval     = col_r[`HRAMP_LOG2+7:`HRAMP_LOG2];
    assign step_blk = col_r[15:`STEP_BLOCK_LOG2];
    assign sval     = step_value(step_blk);
    assign line_end = (col_r == `LINE_WIDTH_RST - 16'h0001);

    always @* begin
        case (pat_sel)
        `PAT_STEPPED: pat_nxt = sval;
        `PAT_HRAMP:   pat_nxt = hval;
        `PAT_VRAMP:   pat_nxt = vval_r;
        `PAT_DIAG:    pat_nxt = hval + vval_r;
        default:      pat_nxt = 8'h00;
        endcase
    end

    // pixel source: test image or sensor stream
    always @* begin
        if (ctrl_r[`CTRL_PAT_EN]) begin
            out_pix_nxt   = pat_nxt;
            out_valid_nxt = 1'b1;
        end else begin
            out_pix_nxt   = sensor_pix_i;
            out_valid_nxt = sensor_valid_i;
        end
    end

    // fault word update
    always @* begin
        fault_nxt = fault_r;
        if (refresh)
            fault_nxt = check_faults_i;
        else
            fault_nxt = fault_r | check_faults_i;
        fault_nxt[`FLT_OVERHEAT] = overheat_i;
        if (save_setup_ok_i)
            fault_nxt[`FLT_NO_USER_SETUP] = 1'b0;
        if (save_offset_ok_i)
            fault_nxt[`FLT_NO_OFFSET_TBL] = 1'b0;
        if (save_gain_ok_i)
            fault_nxt[`FLT_NO_GAIN_TBL] = 1'b0;
    end
    assign fault_rise = |(fault_nxt & ~fault_r);

    always @* begin
        case (adr_i)
        `REG_CTRL:        rd_nxt = ctrl_r;
        `REG_FAULT:       rd_nxt = fault_r;
        `REG_INDICATOR:   rd_nxt = {30'h0, indicator_state_i};
        `REG_LINE_PERIOD: rd_nxt = {16'h0, period_r};
        `REG_IRQ_STATUS:  rd_nxt = {29'h0, irq_stat_r};
        `REG_IRQ_MASK:    rd_nxt = {29'h0, irq_mask_r};
        default:          rd_nxt = 32'h00000000;
        endcase
    end

    // bus answer: ack one cycle after the request, read data with it
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
            if (rd_req)
                dat_o <= rd_nxt;
        end
    end

    // control and line period; the refresh bit is never stored
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r   <= `REG_DEFAULT;
            period_r <= `LINE_PERIOD_RST;
        end else begin
            if (wr_ctrl)
                ctrl_r <= mask_write(ctrl_r, dat_i, sel_i) & `CTRL_WR_MASK;
            if (wr_period)
                period_r <= period_wr[15:0];
        end
    end

    // fault word
    always @(posedge clk_i) begin
        if (rst_i)
            fault_r <= 32'h00000000;
        else
            fault_r <= fault_nxt;
    end

    // interrupt status and mask; set wins over write-one-to-clear
    always @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask_r <= 3'h0;
            irq_stat_r <= 3'h0;
        end else begin
            if (wr_irq_mask)
                irq_mask_r <= dat_i[2:0];
            irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
        end
    end

    // trigger pin: three flip-flops, a level counts once 2 and 3 agree
    always @(posedge clk_i) begin
        if (rst_i) begin
            trg_sync_r <= 3'h0;
            trg_prev_r <= 1'b0;
        end else begin
            trg_sync_r <= {trg_sync_r[1:0], ext_trigger_i};
            if (trg_sync_r[1] == trg_sync_r[2])
                trg_prev_r <= trg_sync_r[2];
        end
    end

    // internal line timer, held at reload while triggering externally
    always @(posedge clk_i) begin
        if (rst_i)
            rate_cnt_r <= 16'h0000;
        else if (rate_cnt_r == 16'h0000 || !trig_int)
            rate_cnt_r <= period_r - 16'h0001;
        else
            rate_cnt_r <= rate_cnt_r - 16'h0001;
    end

    // line sequencer and pixel output
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_r      <= ST_IDLE;
            col_r        <= 16'h0000;
            line_cnt_r   <= 16'h0000;
            vval_r       <= `VRAMP_FIRST;
            pix_o        <= 8'h00;
            pix_valid_o  <= 1'b0;
            line_start_o <= 1'b0;
        end else begin
            line_start_o <= 1'b0;
            pix_valid_o  <= 1'b0;
            case (state_r)
            ST_IDLE: begin
                if (line_go) begin
                    state_r      <= ST_LINE;
                    col_r        <= 16'h0000;
                    line_start_o <= 1'b1;
                end
            end
            ST_LINE: begin
                pix_o       <= out_pix_nxt;
                pix_valid_o <= out_valid_nxt;
                col_r       <= col_r + 16'h0001;
                if (line_end) begin
                    state_r    <= ST_IDLE;
                    line_cnt_r <= line_cnt_r + 16'h0001;
                    vval_r     <= vramp_next(line_cnt_r, vval_r);
                end
            end
            default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule

// ==== core/diag_defines.vh ====
// register map, fields and constants of the diagnostic block
`ifndef DIAG_DEFINES_VH
`define DIAG_DEFINES_VH

// register word offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_FAULT       8'h04
`define REG_INDICATOR   8'h08
`define REG_LINE_PERIOD 8'h0C
`define REG_IRQ_STATUS  8'h10
`define REG_IRQ_MASK    8'h14
`define REG_DEFAULT     32'h00000000

// control register fields
`define CTRL_PAT_EN     0
`define CTRL_PAT_LO     1
`define CTRL_PAT_HI     2
`define CTRL_TRIG_INT   3
`define CTRL_REFRESH    4

// pattern selections
`define PAT_STEPPED     2'h0
`define PAT_HRAMP       2'h1
`define PAT_VRAMP       2'h2
`define PAT_DIAG        2'h3

// stepped pattern
`define STEP_START      8'h40
`define STEP_INC        8'h04
`define STEP_LAST       8'hBC
`define STEP_BLOCK_LOG2 9
`define STEP_LAST_BLK   7'h1F
`define CTRL_WR_MASK    32'h0000000F
// horizontal ramp: one step per 32 pixels
`define HRAMP_LOG2      5
// vertical ramp
`define VRAMP_FIRST     8'h05
`define VRAMP_SECOND    8'h0C
`define VRAMP_INC       8'h03

// fault word bits
`define FLT_SERIAL_BUS     0
`define FLT_OVERHEAT       10
`define FLT_NO_OFFSET_TBL  12
`define FLT_NO_GAIN_TBL    13
`define FLT_NO_USER_SETUP  16
`define FLT_FALLBACK_IMAGE 24

// interrupt status bits
`define IRQ_FAULT_RISE  0
`define IRQ_LINE_DONE   1
`define IRQ_REFRESH     2

`define LINE_PERIOD_RST 16'h0100
`define LINE_WIDTH_RST  16'h37E0
`endif

// ==== testbench/diag_selftest_assertions.sv ====
// port-level checks of the diagnostic block
`timescale 1ns/10ps
`include "diag_defines.vh"
module diag_selftest_assertions (
    // watched ports
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire        we_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        pix_valid_o,
    input wire        line_start_o,
    input wire        overheat_i,
    input wire [1:0]  indicator_state_i,
    input wire [1:0]  indicator_o
);
    reg [15:0] run_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence req_s;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence rd_s(a);
        req_s ##0 (!we_i && adr_i == a);
    endsequence
    // pixels counted since the last line start
    always @(posedge clk_i)
        if (rst_i || line_start_o)
            run_r <= 16'h0000;
        else if (pix_valid_o)
            run_r <= run_r + 16'h0001;
    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    a_ack_latency: assert property (req_s |=> ack_o)
        else $error("ack late");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_indicator_mirror: assert property (indicator_o == indicator_state_i)
        else $error("indicator differs");
    a_overheat_read: assert property (overheat_i [*4] ##0 rd_s(`REG_FAULT)
        |=> ack_o && dat_o[`FLT_OVERHEAT])
        else $error("overheat bit missing");
    a_unmapped_zero: assert property (rd_s(8'h20) |=> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_pixels_follow: assert property (line_start_o |=> pix_valid_o)
        else $error("no pixel after line start");
    a_line_width: assert property ($fell(pix_valid_o) |-> run_r == 16'h37E0)
        else $error("line width wrong");
endmodule
bind diag_selftest diag_selftest_assertions diag_selftest_assertions_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
    .pix_valid_o(pix_valid_o), .line_start_o(line_start_o),
    .overheat_i(overheat_i), .indicator_state_i(indicator_state_i),
    .indicator_o(indicator_o));

// ==== testbench/grabber_model.sv ====
// frame grabber model: line capture and trigger source
`timescale 1ns/10ps
module grabber_model (
    // link from the block
    input  wire       clk_i,
    input  wire [7:0] pix_i,
    input  wire       pix_valid_i,
    input  wire       line_start_i,
    // trigger to the block
    output logic      ext_trigger_o
);
    logic [7:0] line_mem [0:16383];
    int         col = 0;
    int         cnt = 0;
    int         lines = 0;
    initial ext_trigger_o = 1'b0;
    always @(posedge clk_i) begin
        if (line_start_i)
            col = 0;
        if (pix_valid_i) begin
            line_mem[col] = pix_i;
            col = col + 1;
        end else if (col > 0) begin
            cnt = col;
            col = 0;
            lines = lines + 1;
        end
    end
    // pulse long enough for the pin synchroniser
    task trig;
        @(posedge clk_i);
        ext_trigger_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        ext_trigger_o <= 1'b0;
    endtask
endmodule

// ==== testbench/diag_selftest_tb_top.sv ====
// self-checking bench of the diagnostic block
`timescale 1ns/10ps
`include "diag_defines.vh"
module diag_selftest_tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] check_faults_i = 32'h0;
    logic        overheat_i = 1'b0;
    logic [2:0]  save_i = 3'h0;
    logic [1:0]  indicator_state_i = 2'h2;
    logic        sensor_valid_i = 1'b0;
    wire  [31:0] dat_o;
    wire  [7:0]  pix_o;
    wire  [1:0]  indicator_o;
    wire         ack_o, pix_valid_o, line_start_o, ext_trigger_i, irq_o;
    logic [31:0] q;
    int          n_errors = 0;
    int          n_checks = 0;
    always #2 clk_i = ~clk_i;
    diag_selftest diag_selftest_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .sensor_pix_i(8'hA5),
        .sensor_valid_i(sensor_valid_i), .ext_trigger_i(ext_trigger_i),
        .pix_o(pix_o), .pix_valid_o(pix_valid_o),
        .line_start_o(line_start_o), .check_faults_i(check_faults_i),
        .overheat_i(overheat_i), .save_setup_ok_i(save_i[2]),
        .save_offset_ok_i(save_i[1]), .save_gain_ok_i(save_i[0]),
        .indicator_state_i(indicator_state_i),
        .indicator_o(indicator_o), .irq_o(irq_o));
    grabber_model grabber_model_inst (
        .clk_i(clk_i), .pix_i(pix_o), .pix_valid_i(pix_valid_o),
        .line_start_i(line_start_o), .ext_trigger_o(ext_trigger_i));
    task results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'h3, w, a, d, 4'hF};
        do @(posedge clk_i); while (ack_o !== 1'b1 && ++i < 100);
        q = dat_o;
        {cyc_i, stb_i, we_i} <= 3'h0;
        if (i >= 100) begin
            n_errors++;
            results();
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task pulse(input logic [31:0] f);
        @(posedge clk_i);
        check_faults_i <= f;
        @(posedge clk_i);
        check_faults_i <= 32'h0;
    endtask
    function automatic logic [7:0] ex(int p, int c, int n);
        logic [7:0] h, v, s;
        h = 8'(c >> 5);
        v = (n == 0) ? 8'h05 : 8'(12 + 3 * (n - 1));
        s = ((c >> 9) > 31) ? 8'hBC : 8'(64 + 4 * (c >> 9));
        case (p)
            0: ex = s;
            1: ex = h;
            2: ex = v;
            default: ex = h + v;
        endcase
    endfunction
    initial begin
        int p, c, i;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`REG_FAULT, 32'h0);
        rd(`REG_INDICATOR, 32'h2);
        rd(8'h20, 32'h0);
        wb(1'b1, `REG_IRQ_MASK, 32'h1);
        pulse(32'h01000001);
        rd(`REG_FAULT, 32'h01000001);
        overheat_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(`REG_FAULT, 32'h01000401);
        overheat_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        rd(`REG_FAULT, 32'h01000001);
        pulse(32'h00013000);
        rd(`REG_FAULT, 32'h01013001);
        @(posedge clk_i) save_i <= 3'h7;
        @(posedge clk_i) save_i <= 3'h0;
        rd(`REG_FAULT, 32'h01000001);
        wb(1'b1, `REG_CTRL, 32'h10);
        repeat (4) @(posedge clk_i);
        rd(`REG_FAULT, 32'h0);
        @(negedge clk_i) chk({31'h0, irq_o}, 32'h1);
        wb(1'b1, `REG_IRQ_STATUS, 32'h1);
        @(negedge clk_i) chk({31'h0, irq_o}, 32'h0);
        for (p = 0; p < 4; p++) begin
            wb(1'b1, `REG_CTRL, 32'(p * 2 + 1));
            grabber_model_inst.trig();
            for (i = 0; i < 20000 && grabber_model_inst.lines <= p; i++)
                @(posedge clk_i);
            if (i >= 20000) begin
                n_errors++;
                results();
            end
            chk(grabber_model_inst.cnt, 32'h37E0);
            for (c = 0; c < 14304; c++)
                chk(grabber_model_inst.line_mem[c], ex(p, c, p));
        end
        sensor_valid_i <= 1'b1;
        wb(1'b1, `REG_CTRL, 32'h8);
        grabber_model_inst.trig();
        for (i = 0; i < 400 && line_start_o !== 1'b1; i++)
            @(posedge clk_i);
        chk(32'(i > 200 && i < 300), 32'h1);
        for (i = 0; i < 20000 && grabber_model_inst.lines <= 4; i++)
            @(posedge clk_i);
        if (i >= 20000) begin
            n_errors++;
            results();
        end
        chk(grabber_model_inst.cnt, 32'h37E0);
        chk(grabber_model_inst.line_mem[0], 32'hA5);
        chk(grabber_model_inst.line_mem[14303], 32'hA5);
        @(negedge clk_i) chk({31'h0, irq_o}, 32'h0);
        results();
    end
endmodule
